// ===== hdl/core_memory_register_map.sv
// memory decoder and register file with working-group and page mapping
`timescale 1ns/10ps
`default_nettype none
module core_memory_register_map #(
   parameter int PAGES = 4,
   parameter bit STRAP_OPTION = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic strap_pin,
   input wire core_memory_pkg::core_cmd_t cmd,
   input wire logic [7:0] cmd_arg,
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   input wire logic mem_fetch,
   input wire core_memory_pkg::ref_kind_t mem_kind,
   input wire logic mem_explicit_prog,
   output logic mem_program,
   output core_memory_pkg::mem_target_t mem_target,
   output logic ext_cycle,
   output logic ext_program_sel,
   output logic vector_area,
   output logic vector_high_byte,
   output logic rom_enabled,
   output logic space_is_program,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic reg_word,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [7:0] bit_mask,
   input wire logic bit_set,
   input wire logic bit_clr,
   output logic [15:0] reg_rdata,
   output logic [7:0] reg_phys,
   output logic twin_mode,
   output logic [7:0] page_now
);
   import core_memory_pkg::*;

   typedef struct packed {
      logic prog_sel;
      logic twin;
      logic strap_taken;
      logic rom_en;
      logic [15:0] rdata;
      logic [7:0] phys;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [7:0] gp_q [0:223];
   logic [7:0] sys_q [0:15];
   logic [7:0] page_q [0:PAGES*PAGE_REGS-1];

   logic [3:0] group_n;
   logic [7:0] phys_addr;
   logic [7:0] phys_next;
   logic is_paged;
   logic is_sys;
   logic sel_prog;
   logic in_rom;
   logic in_ram;
   logic [7:0] pg;

   // working-register escape and pointer mapping
   always_comb begin
      group_n = reg_addr[7:4];
      phys_addr = reg_addr;
      if (group_n == WORKING_ESCAPE) begin
         if (!s_q.twin) begin
            phys_addr = {sys_q[4'h8][7:4], reg_addr[3:0]};
         end else if (!reg_addr[3]) begin
            phys_addr = {sys_q[4'h8][7:3], reg_addr[2:0]};
         end else begin
            phys_addr = {sys_q[4'h9][7:3], reg_addr[2:0]};
         end
      end
      phys_next = phys_addr + 8'h01;
   end

   assign is_paged = phys_addr[7:4] == GROUP_PAGED;
   assign is_sys = phys_addr[7:4] == GROUP_SYSTEM;
   assign pg = sys_q[4'ha] % 8'(PAGES);

   // space in use for this reference
   always_comb begin
      sel_prog = s_q.prog_sel;
      if (mem_fetch) begin
         sel_prog = 1'b1;
      end
      case (mem_kind)
         REF_STACK: sel_prog = 1'b0;
         REF_EXPLICIT: sel_prog = mem_explicit_prog;
         default: sel_prog = sel_prog;
      endcase
   end

   assign in_rom = sel_prog && s_q.rom_en && mem_addr <= ROM_LAST;
   assign in_ram = !sel_prog && mem_addr >= RAM_FIRST && mem_addr <= RAM_LAST;

   always_comb begin
      mem_program = sel_prog;
      vector_area = sel_prog && mem_addr <= VECTOR_LAST;
      vector_high_byte = vector_area && !mem_addr[0];
      if (in_rom) begin
         mem_target = TGT_ROM;
      end else if (in_ram) begin
         mem_target = TGT_RAM;
      end else begin
         mem_target = TGT_EXTERNAL;
      end
      ext_cycle = mem_req && !in_rom && !in_ram;
      ext_program_sel = ext_cycle && sel_prog;
   end

   function automatic logic [7:0] rd8(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a[7:4] == GROUP_PAGED) begin
         v = page_q[pg*PAGE_REGS + int'(a[3:0])];
      end else if (a[7:4] == GROUP_SYSTEM) begin
         v = sys_q[a[3:0]];
      end else begin
         v = gp_q[a];
      end
      return v;
   endfunction : rd8

   // control state
   always_comb begin
      s_d = s_q;
      case (cmd)
         CMD_SELECT_DATA: s_d.prog_sel = 1'b0;
         CMD_SELECT_PROGRAM: s_d.prog_sel = 1'b1;
         CMD_SET_SINGLE: s_d.twin = 1'b0;
         CMD_SET_LOW_HALF: s_d.twin = 1'b1;
         CMD_SET_HIGH_HALF: s_d.twin = 1'b1;
         default: s_d.twin = s_q.twin;
      endcase
      if (!s_q.strap_taken) begin
         s_d.strap_taken = 1'b1;
         s_d.rom_en = STRAP_OPTION ? strap_pin : 1'b1;
      end
      s_d.phys = phys_addr;
      if (reg_rd) begin
         s_d.rdata = {reg_word ? rd8(phys_next) : 8'h00, rd8(phys_addr)};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // register file storage; pair writes take low byte at the mapped address, high byte at the next
   always_ff @(posedge clk) begin
      logic [7:0] v;
      logic [7:0] a;
      if (ce) begin
         for (int k = 0; k < 2; k++) begin
            a = k == 0 ? phys_addr : phys_next;
            v = k == 0 ? reg_wdata[7:0] : reg_wdata[15:8];
            if (!reg_wr && k == 0 && (bit_set || bit_clr)) begin
               v = bit_set ? (rd8(a) | bit_mask) : (rd8(a) & ~bit_mask);
            end
            if ((reg_wr && (k == 0 || reg_word)) || (k == 0 && (bit_set || bit_clr))) begin
               if (a[7:4] == GROUP_PAGED) begin
                  page_q[pg*PAGE_REGS + int'(a[3:0])] <= v;
               end else if (a[7:4] == GROUP_SYSTEM) begin
                  sys_q[a[3:0]] <= v;
               end else begin
                  gp_q[a] <= v;
               end
            end
         end
         if (cmd == CMD_SET_PAGE) begin
            sys_q[4'ha] <= cmd_arg;
         end else if (cmd == CMD_SET_SINGLE || cmd == CMD_SET_LOW_HALF) begin
            sys_q[4'h8] <= cmd_arg;
         end else if (cmd == CMD_SET_HIGH_HALF) begin
            sys_q[4'h9] <= cmd_arg;
         end
      end
   end

   assign rom_enabled = s_q.rom_en;
   assign space_is_program = s_q.prog_sel;
   assign reg_rdata = s_q.rdata;
   assign reg_phys = s_q.phys;
   assign twin_mode = s_q.twin;
   assign page_now = sys_q[4'ha];

   // checks
   space_persist_a: assert property (@(posedge clk) disable iff (rst)
      ce && cmd == CMD_SELECT_DATA |=> !space_is_program)
      else $error("data select did not take");
   prog_persist_a: assert property (@(posedge clk) disable iff (rst)
      ce && cmd == CMD_SELECT_PROGRAM |=> space_is_program)
      else $error("program select did not take");
   stack_data_a: assert property (@(posedge clk) disable iff (rst)
      mem_kind == REF_STACK |-> !mem_program)
      else $error("stack reference not in data space");
   rom_range_a: assert property (@(posedge clk) disable iff (rst)
      mem_program && rom_enabled && mem_addr <= 16'h3fff |-> mem_target == TGT_ROM)
      else $error("rom range not decoded");
   ram_range_a: assert property (@(posedge clk) disable iff (rst)
      !mem_program && mem_addr >= 16'h0200 && mem_addr <= 16'h02ff |-> mem_target == TGT_RAM)
      else $error("ram range not decoded");
   ext_select_a: assert property (@(posedge clk) disable iff (rst)
      ext_cycle |-> ext_program_sel == mem_program)
      else $error("select pin mismatch");
   fetch_ext_a: assert property (@(posedge clk) disable iff (rst)
      mem_req && mem_fetch && mem_kind == REF_NORMAL && mem_addr > 16'h3fff |-> ext_cycle)
      else $error("high fetch not external");
   strap_hold_a: assert property (@(posedge clk) disable iff (rst)
      ce && $past(ce) && s_q.strap_taken && $past(s_q.strap_taken) |-> $stable(rom_enabled))
      else $error("strap changed after capture");
   twin_mode_a: assert property (@(posedge clk) disable iff (rst)
      ce && cmd == CMD_SET_HIGH_HALF |=> twin_mode)
      else $error("twin mode not set");

   // space choice per reference
   fetch_prog_a: assert property (@(posedge clk) disable iff (rst)
      mem_fetch && mem_kind == REF_NORMAL |-> mem_program)
      else $error("fetch not in program space");
   normal_space_a: assert property (@(posedge clk) disable iff (rst)
      !mem_fetch && mem_kind == REF_NORMAL |-> mem_program == space_is_program)
      else $error("reference ignores selected space");
   explicit_space_a: assert property (@(posedge clk) disable iff (rst)
      mem_kind == REF_EXPLICIT |-> mem_program == mem_explicit_prog)
      else $error("copy operand space not from encoding");
   stack_override_a: assert property (@(posedge clk) disable iff (rst)
      mem_kind == REF_STACK && mem_fetch |-> !mem_program)
      else $error("stack reference left data space");
   space_hold_a: assert property (@(posedge clk) disable iff (rst)
      ce && cmd != CMD_SELECT_DATA && cmd != CMD_SELECT_PROGRAM |=> $stable(space_is_program))
      else $error("space changed without command");

   // on-chip ranges and external cycles
   rom_only_prog_a: assert property (@(posedge clk) disable iff (rst)
      mem_target == TGT_ROM |-> mem_program && rom_enabled && mem_addr <= ROM_LAST)
      else $error("rom decoded outside its range");
   ram_only_data_a: assert property (@(posedge clk) disable iff (rst)
      mem_target == TGT_RAM |-> !mem_program && mem_addr >= RAM_FIRST && mem_addr <= RAM_LAST)
      else $error("ram decoded outside its range");
   prog_ext_a: assert property (@(posedge clk) disable iff (rst)
      mem_req && mem_program && mem_addr > ROM_LAST |-> ext_cycle)
      else $error("program above rom not external");
   data_ext_a: assert property (@(posedge clk) disable iff (rst)
      mem_req && !mem_program && (mem_addr < RAM_FIRST || mem_addr > RAM_LAST) |-> ext_cycle)
      else $error("data outside ram not external");
   external_program_strap_ext_a: assert property (@(posedge clk) disable iff (rst)
      mem_req && mem_program && !rom_enabled |-> ext_cycle)
      else $error("program not external with rom off");
   ram_kept_a: assert property (@(posedge clk) disable iff (rst)
      !rom_enabled && !mem_program && mem_addr >= RAM_FIRST && mem_addr <= RAM_LAST
      |-> mem_target == TGT_RAM)
      else $error("ram lost with rom off");
   no_req_idle_a: assert property (@(posedge clk) disable iff (rst)
      !mem_req |-> !ext_cycle && !ext_program_sel)
      else $error("external cycle without request");
   target_ext_a: assert property (@(posedge clk) disable iff (rst)
      ext_cycle |-> mem_target == TGT_EXTERNAL)
      else $error("external cycle to on-chip target");
   ext_target_req_a: assert property (@(posedge clk) disable iff (rst)
      mem_req && mem_target == TGT_EXTERNAL |-> ext_cycle)
      else $error("external target without cycle");
   data_sel_low_a: assert property (@(posedge clk) disable iff (rst)
      ext_cycle && !mem_program |-> !ext_program_sel)
      else $error("select high for data cycle");

   // vector table area
   vector_span_a: assert property (@(posedge clk) disable iff (rst)
      vector_area |-> mem_program && mem_addr <= VECTOR_LAST)
      else $error("vector area outside table");
   vector_even_a: assert property (@(posedge clk) disable iff (rst)
      vector_area && !mem_addr[0] |-> vector_high_byte)
      else $error("even vector byte not high");
   vector_odd_a: assert property (@(posedge clk) disable iff (rst)
      vector_area && mem_addr[0] |-> !vector_high_byte)
      else $error("odd vector byte marked high");

   // strap capture
   strap_capture_a: assert property (@(posedge clk) disable iff (rst)
      ce && !s_q.strap_taken |=> rom_enabled == (STRAP_OPTION ? $past(strap_pin) : 1'b1))
      else $error("strap level not captured");
   rom_off_a: assert property (@(posedge clk) disable iff (rst)
      !s_q.strap_taken |-> !rom_enabled)
      else $error("rom on before strap capture");
   taken_stays_a: assert property (@(posedge clk) disable iff (rst)
      s_q.strap_taken |=> s_q.strap_taken)
      else $error("strap captured twice");

   // pointers, page and working registers
   page_load_a: assert property (@(posedge clk) disable iff (rst)
      ce && cmd == CMD_SET_PAGE |=> page_now == $past(cmd_arg))
      else $error("page pointer not loaded");
   page_range_a: assert property (@(posedge clk) disable iff (rst)
      pg < 8'(PAGES))
      else $error("page index out of range");
   paged_group_a: assert property (@(posedge clk) disable iff (rst)
      is_paged |-> !is_sys)
      else $error("paged and system group overlap");
   pointer0_load_a: assert property (@(posedge clk) disable iff (rst)
      ce && (cmd == CMD_SET_SINGLE || cmd == CMD_SET_LOW_HALF) |=> sys_q[4'h8] == $past(cmd_arg))
      else $error("pointer 0 not loaded");
   pointer1_load_a: assert property (@(posedge clk) disable iff (rst)
      ce && cmd == CMD_SET_HIGH_HALF |=> sys_q[4'h9] == $past(cmd_arg))
      else $error("pointer 1 not loaded");
   single_mode_a: assert property (@(posedge clk) disable iff (rst)
      ce && cmd == CMD_SET_SINGLE |=> !twin_mode)
      else $error("single mode not set");
   low_half_a: assert property (@(posedge clk) disable iff (rst)
      ce && cmd == CMD_SET_LOW_HALF |=> twin_mode)
      else $error("twin mode not set by low half");
   twin_hold_a: assert property (@(posedge clk) disable iff (rst)
      ce && cmd == CMD_NONE |=> $stable(twin_mode))
      else $error("mode changed without command");
   direct_map_a: assert property (@(posedge clk) disable iff (rst)
      reg_addr[7:4] != WORKING_ESCAPE |-> phys_addr == reg_addr)
      else $error("direct address remapped");
   escape_map_a: assert property (@(posedge clk) disable iff (rst)
      reg_addr[7:4] == WORKING_ESCAPE |-> phys_addr[2:0] == reg_addr[2:0])
      else $error("working offset lost");
   single_map_a: assert property (@(posedge clk) disable iff (rst)
      reg_addr[7:4] == WORKING_ESCAPE && !twin_mode |-> phys_addr[7:4] == sys_q[4'h8][7:4])
      else $error("single group base wrong");
   twin_low_a: assert property (@(posedge clk) disable iff (rst)
      reg_addr[7:4] == WORKING_ESCAPE && twin_mode && !reg_addr[3]
      |-> phys_addr[7:3] == sys_q[4'h8][7:3])
      else $error("low half base wrong");
   twin_high_a: assert property (@(posedge clk) disable iff (rst)
      reg_addr[7:4] == WORKING_ESCAPE && twin_mode && reg_addr[3]
      |-> phys_addr[7:3] == sys_q[4'h9][7:3])
      else $error("high half base wrong");
   phys_reg_a: assert property (@(posedge clk) disable iff (rst)
      ce |=> reg_phys == $past(phys_addr))
      else $error("mapped address not registered");

   // read data and clock enable
   byte_read_a: assert property (@(posedge clk) disable iff (rst)
      ce && reg_rd && !reg_word |=> reg_rdata[15:8] == 8'h00)
      else $error("byte read upper half not clear");
   rdata_hold_a: assert property (@(posedge clk) disable iff (rst)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without read");
   freeze_a: assert property (@(posedge clk) disable iff (rst)
      !ce |=> $stable(space_is_program) && $stable(twin_mode) && $stable(rom_enabled))
      else $error("state moved with enable low");
   ext_cov: cover property (@(posedge clk) disable iff (rst) ext_cycle && ext_program_sel);
   ram_cov: cover property (@(posedge clk) disable iff (rst) mem_target == TGT_RAM);
   page_cov: cover property (@(posedge clk) disable iff (rst) reg_rd && is_paged);
   sys_cov: cover property (@(posedge clk) disable iff (rst) reg_wr && is_sys);
endmodule : core_memory_register_map
`default_nettype wire

// ===== hdl/core_memory_pkg.sv
// constants for the core memory and register-file map
package core_memory_pkg;
   localparam int ADDR_W = 16;
   localparam logic [16:0] SPACE_BYTES = 17'h10000;
   localparam logic [15:0] ROM_LAST = 16'h3fff;
   localparam logic [15:0] RAM_FIRST = 16'h0200;
   localparam logic [15:0] RAM_LAST = 16'h02ff;
   localparam logic [15:0] VECTOR_LAST = 16'h00ff;
   localparam logic [15:0] EXT_DATA_LOCATIONS = 16'hff00;
   localparam logic [7:0] PORT0_DATA_OFS = 8'he0;
   localparam logic [7:0] PORT1_DATA_OFS = 8'he1;
   localparam logic [7:0] PORT2_DATA_OFS = 8'he2;
   localparam logic [7:0] PORT3_DATA_OFS = 8'he3;
   localparam logic [7:0] PORT4_DATA_OFS = 8'he4;
   localparam logic [7:0] PORT5_DATA_OFS = 8'he5;
   localparam logic [7:0] CENTRAL_INTERRUPT_CONTROL_OFS = 8'he6;
   localparam logic [7:0] ALU_FLAGS_OFS = 8'he7;
   localparam logic [7:0] WORKING_GROUP_POINTER_0_OFS = 8'he8;
   localparam logic [7:0] WORKING_GROUP_POINTER_1_OFS = 8'he9;
   localparam logic [7:0] PERIPHERAL_PAGE_SELECT_OFS = 8'hea;
   localparam logic [7:0] CORE_MODE_OFS = 8'heb;
   localparam logic [7:0] USER_STACK_PTR_HIGH_OFS = 8'hec;
   localparam logic [7:0] USER_STACK_PTR_LOW_OFS = 8'hed;
   localparam logic [7:0] SYSTEM_STACK_PTR_HIGH_OFS = 8'hee;
   localparam logic [7:0] SYSTEM_STACK_PTR_LOW_OFS = 8'hef;
   localparam logic [3:0] GROUP_SYSTEM = 4'he;
   localparam logic [3:0] GROUP_PAGED = 4'hf;
   localparam logic [3:0] WORKING_ESCAPE = 4'hd;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] CORE_MODE_RESET = 8'hc0;
   localparam int PAGE_REGS = 16;
   // memory-reference kinds from the core
   typedef enum logic [1:0] {
      REF_NORMAL,
      REF_STACK,
      REF_EXPLICIT
   } ref_kind_t;
   // space-control commands
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_SELECT_DATA,
      CMD_SELECT_PROGRAM,
      CMD_SET_PAGE,
      CMD_SET_SINGLE,
      CMD_SET_LOW_HALF,
      CMD_SET_HIGH_HALF
   } core_cmd_t;
   // target of a memory reference
   typedef enum logic [1:0] {
      TGT_ROM,
      TGT_RAM,
      TGT_EXTERNAL
   } mem_target_t;
endpackage : core_memory_pkg

// ===== bench/ext_mem_model.sv
// behavioural external memory that counts bus cycles per space
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
   input wire logic clk,
   input wire logic mem_req,
   input wire logic ext_cycle,
   input wire logic ext_program_sel
);
   int n_prog = 0;
   int n_data = 0;
   // the select line splits one bus into two spaces
   always @(posedge clk) begin
      if (mem_req && ext_cycle && ext_program_sel) n_prog++;
      if (mem_req && ext_cycle && !ext_program_sel) n_data++;
   end
endmodule : ext_mem_model
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the core memory and register map
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
   import core_memory_pkg::*;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, strap_pin = 1'b1, mem_req = 1'b0, mem_fetch = 1'b0;
   logic mem_explicit_prog = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0, reg_word = 1'b0;
   logic bit_set = 1'b0, bit_clr = 1'b0;
   logic [7:0] cmd_arg = 8'h00, reg_addr = 8'h00, bit_mask = 8'h00;
   logic [15:0] mem_addr = 16'h0000, reg_wdata = 16'h0000;
   core_cmd_t cmd = CMD_NONE;
   ref_kind_t mem_kind = REF_NORMAL;
   logic mem_program, ext_cycle, ext_program_sel, vector_area, vector_high_byte;
   logic rom_enabled, space_is_program, twin_mode;
   logic [15:0] reg_rdata;
   logic [7:0] reg_phys, page_now;
   mem_target_t mem_target;
   int n_mismatch = 0, tests_run = 0, cycles = 0, exp_np = 0, exp_nd = 0;
   int seed = 32'he09d;
   logic exp_space = 1'b0, exp_rom = 1'b1;
   localparam logic [15:0] TBL [11] = '{16'h0000, 16'h0001, 16'h00ff, 16'h0100, 16'h01ff,
      16'h0200, 16'h02ff, 16'h0300, 16'h3fff, 16'h4000, 16'hffff};
   core_memory_register_map #(.PAGES(4), .STRAP_OPTION(1'b1)) i_dut (.clk, .rst, .ce,
      .strap_pin, .cmd, .cmd_arg, .mem_req, .mem_addr, .mem_fetch, .mem_kind,
      .mem_explicit_prog, .mem_program, .mem_target, .ext_cycle, .ext_program_sel,
      .vector_area, .vector_high_byte, .rom_enabled, .space_is_program, .reg_rd, .reg_wr,
      .reg_word, .reg_addr, .reg_wdata, .bit_mask, .bit_set, .bit_clr, .reg_rdata,
      .reg_phys, .twin_mode, .page_now);
   ext_mem_model i_mem (.clk, .mem_req, .ext_cycle, .ext_program_sel);
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic give_verdict;
      $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic cyc;
      @(posedge clk);
      #1;
   endtask : cyc
   task automatic do_reset(logic s);
      strap_pin = s;
      rst = 1'b1;
      repeat (6) cyc();
      rst = 1'b0;
      repeat (3) cyc();
      strap_pin = ~s; // pin is free once captured
      exp_rom = s;
      exp_space = 1'b0;
   endtask : do_reset
   task automatic docmd(core_cmd_t c, logic [7:0] v);
      cmd = c;
      cmd_arg = v;
      cyc();
      cmd = CMD_NONE;
      cyc();
      if (c == CMD_SELECT_PROGRAM) exp_space = 1'b1;
      if (c == CMD_SELECT_DATA) exp_space = 1'b0;
   endtask : docmd
   task automatic chk_dec(logic [15:0] a, logic f, ref_kind_t k, logic e);
      logic p;
      mem_target_t t;
      mem_addr = a;
      mem_fetch = f;
      mem_kind = k;
      mem_explicit_prog = e;
      mem_req = 1'b1;
      #1;
      p = (k == REF_EXPLICIT) ? e : (k == REF_STACK) ? 1'b0 : (f | exp_space);
      t = (p && exp_rom && a <= ROM_LAST) ? TGT_ROM :
          (!p && a >= RAM_FIRST && a <= RAM_LAST) ? TGT_RAM : TGT_EXTERNAL;
      `CHK(mem_program, p)
      `CHK(mem_target, t)
      `CHK(ext_cycle, t == TGT_EXTERNAL)
      if (t == TGT_EXTERNAL) `CHK(ext_program_sel, p)
      `CHK(vector_area, p && a <= VECTOR_LAST)
      if (p && a <= VECTOR_LAST) `CHK(vector_high_byte, ~a[0])
      if (t == TGT_EXTERNAL && p) exp_np++;
      if (t == TGT_EXTERNAL && !p) exp_nd++;
      cyc();
   endtask : chk_dec
   task automatic sweep;
      logic [31:0] r;
      for (int s = 0; s < 2; s++) begin
         mem_req = 1'b0;
         docmd(s ? CMD_SELECT_PROGRAM : CMD_SELECT_DATA, 8'h00);
         foreach (TBL[i]) begin
            chk_dec(TBL[i], 1'b0, REF_NORMAL, 1'b0);
            chk_dec(TBL[i], 1'b1, REF_NORMAL, 1'b0);
            chk_dec(TBL[i], 1'b0, REF_STACK, 1'b0);
            chk_dec(TBL[i], 1'b0, REF_EXPLICIT, i[0]);
         end
         for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            chk_dec(r[31:16], r[3] & (r[1:0] == 2'd0), ref_kind_t'(r[1:0] % 3), r[2]);
         end
      end
      mem_req = 1'b0;
   endtask : sweep
   task automatic wr(logic [7:0] a, logic [15:0] d, logic w);
      reg_addr = a;
      reg_wdata = d;
      reg_word = w;
      reg_wr = 1'b1;
      cyc();
      reg_wr = 1'b0;
      cyc();
   endtask : wr
   task automatic rd(logic [7:0] a, logic w, output logic [15:0] d);
      reg_addr = a;
      reg_word = w;
      reg_rd = 1'b1;
      cyc();
      reg_rd = 1'b0;
      d = reg_rdata;
      cyc();
   endtask : rd
   task automatic bop(logic [7:0] a, logic [7:0] m, logic s);
      reg_addr = a;
      bit_mask = m;
      bit_set = s;
      bit_clr = ~s;
      cyc();
      bit_set = 1'b0;
      bit_clr = 1'b0;
      cyc();
   endtask : bop
   initial begin
      logic [15:0] d;
      logic [15:0] v [16];
      logic [7:0] ga [8];
      do_reset(1'b1);
      `CHK(space_is_program, 1'b0)
      `CHK(twin_mode, 1'b0)
      `CHK(rom_enabled, 1'b1)
      docmd(CMD_SELECT_PROGRAM, 8'h00);
      repeat (5) cyc();
      `CHK(space_is_program, 1'b1)
      docmd(CMD_SELECT_DATA, 8'h00);
      `CHK(space_is_program, 1'b0)
      sweep();
      $display("test decode done");
      for (int i = 0; i < 8; i++) begin
         v[i] = $random(seed);
         ga[i] = {i[3:0], 4'($random(seed)) & 4'he};
         wr(ga[i], v[i], 1'b1);
      end
      for (int i = 0; i < 8; i++) begin
         rd(ga[i], 1'b1, d);
         `CHK(d, v[i])
         rd(ga[i] + 8'h01, 1'b0, d);
         `CHK(d[7:0], v[i][15:8])
      end
      for (int i = 0; i < 16; i++) begin
         v[i] = $random(seed);
         wr(PORT0_DATA_OFS + 8'(i), v[i], 1'b0);
         rd(PORT0_DATA_OFS + 8'(i), 1'b0, d);
         `CHK(d[7:0], v[i][7:0])
      end
      $display("test registers done");
      docmd(CMD_SET_PAGE, 8'h00);
      wr(8'hf3, 16'h0055, 1'b0);
      docmd(CMD_SET_PAGE, 8'h01);
      `CHK(page_now, 8'h01)
      wr(8'hf3, 16'h00aa, 1'b0);
      rd(8'hf3, 1'b0, d);
      `CHK(d[7:0], 8'haa)
      docmd(CMD_SET_PAGE, 8'h00);
      rd(8'hf3, 1'b0, d);
      `CHK(d[7:0], 8'h55)
      wr(PORT0_DATA_OFS, 16'h000f, 1'b0);
      bop(PORT0_DATA_OFS, 8'h30, 1'b1);
      rd(PORT0_DATA_OFS, 1'b0, d);
      `CHK(d[7:0], 8'h3f)
      bop(PORT0_DATA_OFS, 8'h03, 1'b0);
      rd(PORT0_DATA_OFS, 1'b0, d);
      `CHK(d[7:0], 8'h3c)
      docmd(CMD_SET_LOW_HALF, 8'h10);
      `CHK(twin_mode, 1'b1)
      docmd(CMD_SET_SINGLE, 8'h20);
      `CHK(twin_mode, 1'b0)
      docmd(CMD_SET_HIGH_HALF, 8'h38);
      `CHK(twin_mode, 1'b1)
      wr(8'hda, 16'h005a, 1'b0);
      `CHK(reg_phys, 8'h3a)
      rd(8'h3a, 1'b0, d);
      `CHK(d[7:0], 8'h5a)
      docmd(CMD_SET_SINGLE, 8'h20);
      wr(8'hd3, 16'h0077, 1'b0);
      `CHK(reg_phys, 8'h23)
      rd(8'h23, 1'b0, d);
      `CHK(d[7:0], 8'h77)
      $display("test paging and pointers done");
      do_reset(1'b0);
      repeat (4) cyc();
      `CHK(rom_enabled, 1'b0)
      sweep();
      `CHK(i_mem.n_prog, exp_np)
      `CHK(i_mem.n_data, exp_nd)
      $display("test external program strap done");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
